// >>> bench/branch_decoder_chk.sv
// Concurrent checks on the decoder's ports
`timescale 1ns/1ps
module branch_decoder_chk import decode_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic fetch_valid_i,
	input wire fetch_t fetch_i,
	input wire cpu_state_t state_i,
	input wire logic bus_8bit_i,
	input wire logic decode_valid_o,
	input wire decode_t decode_o
);
	// ****
	// Handshake, costs, conditions, lock and operand location
	// ****
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	AST_ANSWER: assert property (fetch_valid_i |=> decode_valid_o)
		else $error("no decode one cycle after fetch");
	AST_HOLD: assert property (!decode_valid_o |-> $stable(decode_o))
		else $error("decode changed without a fetch");
	AST_RTN_NEAR: assert property (fetch_valid_i && fetch_i.b0 == OP_RTN_NEAR && !bus_8bit_i
		|=> decode_o.cycles == 16'd16) else $error("near return cost wrong");
	AST_RTN_FAR: assert property (fetch_valid_i && fetch_i.b0 == OP_RTN_FAR_IMM |=>
		decode_o.cycles == ($past(bus_8bit_i) ? 16'd33 : 16'd25)
		&& decode_o.imm16 == {$past(fetch_i.b2), $past(fetch_i.b1)}) else $error("far return wrong");
	AST_JCC_COST: assert property (fetch_valid_i && fetch_i.b0[7:4] == OP_JCC_HI |=>
		decode_o.cycles == (decode_o.taken ? 16'd13 : 16'd4)) else $error("jump cost wrong");
	AST_JCC_ZERO: assert property (fetch_valid_i && fetch_i.b0[7:1] == 7'b0111010 |=>
		decode_o.taken == ($past(state_i.zero) ^ $past(fetch_i.b0[0])))
		else $error("equal jump condition wrong");
	AST_JCZR: assert property (fetch_valid_i && fetch_i.b0 == OP_JCZR |=>
		decode_o.taken == ($past(state_i.count_word) == 16'h0)
		&& decode_o.cycles == (decode_o.taken ? 16'd15 : 16'd5)) else $error("count jump wrong");
	AST_LOOP: assert property (fetch_valid_i && fetch_i.b0 == OP_LOOP |=>
		decode_o.count_next == $past(state_i.count_word) - 16'h1
		&& decode_o.taken == (decode_o.count_next != 16'h0)) else $error("loop wrong");
	AST_OVERFLOW_TRAP: assert property (fetch_valid_i && fetch_i.b0 == OP_OVF_TRAP |=>
		decode_o.cycles == ($past(state_i.ovf) ? 16'd48 : 16'd4)) else $error("trap cost wrong");
	AST_IEXT: assert property (fetch_valid_i && fetch_i.b0 == OP_IEXT |=>
		decode_o.kind == K_IEXT && decode_o.cycles == 16'd28) else $error("exit wrong");
	AST_LOCK: assert property (fetch_valid_i && fetch_i.b0 == OP_LOCK ##1
		fetch_valid_i && fetch_i.b0 == OP_RTN_NEAR |=> decode_o.bus_lock) else $error("lock lost");
	AST_DIRECT: assert property (fetch_valid_i && fetch_i.b0 == OP_BOUND
		&& fetch_i.b1[7:6] == 2'b00 && fetch_i.b1[2:0] == 3'b110 |=>
		decode_o.ol.operand_location == {$past(fetch_i.b3), $past(fetch_i.b2)})
		else $error("direct location wrong");
endmodule : branch_decoder_chk
bind branch_decoder branch_decoder_chk chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.fetch_valid_i(fetch_valid_i), .fetch_i(fetch_i), .state_i(state_i),
	.bus_8bit_i(bus_8bit_i), .decode_valid_o(decode_valid_o), .decode_o(decode_o));

// >>> bench/cpu_branch_and_address_decoder_tb_top.sv
// Self-checking bench for the branch and operand-location decoder
`timescale 1ns/1ps
module cpu_branch_and_address_decoder_tb_top import decode_pkg::*;;
	logic ref_clk_i;
	logic rst_i;
	logic bus_8bit_i;
	logic fetch_valid_i;
	fetch_t fetch_i;
	cpu_state_t state_i;
	logic decode_valid_o;
	decode_t decode_o;
	cpu_state_t st;
	int failures;
	int n_tests;
	prefetch_model m_u (.ref_clk_i(ref_clk_i), .fetch_valid_o(fetch_valid_i),
		.fetch_o(fetch_i), .state_o(state_i));
	branch_decoder dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .fetch_valid_i(fetch_valid_i),
		.fetch_i(fetch_i), .state_i(state_i), .bus_8bit_i(bus_8bit_i),
		.decode_valid_o(decode_valid_o), .decode_o(decode_o));
	// ****
	// Helpers
	// ****
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic run(input logic [7:0] b0, b1, b2, b3);
		m_u.send({b3, b2, b1, b0}, st);
		m_u.idle();
		chk("valid", 16'(decode_valid_o), 16'h1);
	endtask : run
	function automatic logic [15:0] loc(input logic [2:0] s);
		case (s)
			3'd0: return st.base_word + st.source_index;
			3'd1: return st.base_word + st.destination_index;
			3'd2: return st.frame_base_pointer + st.source_index;
			3'd3: return st.frame_base_pointer + st.destination_index;
			3'd4: return st.source_index;
			3'd5: return st.destination_index;
			3'd6: return st.frame_base_pointer;
			default: return st.base_word;
		endcase
	endfunction : loc
	function automatic logic cond(input logic [3:0] c, input cpu_state_t s);
		logic r;
		case (c[3:1])
			3'd0: r = s.ovf;
			3'd1: r = s.carry;
			3'd2: r = s.zero;
			3'd3: r = s.carry | s.zero;
			3'd4: r = s.sign;
			3'd5: r = s.parity;
			3'd6: r = s.sign ^ s.ovf;
			default: r = (s.sign ^ s.ovf) | s.zero;
		endcase
		return r ^ c[0];
	endfunction : cond
	// ****
	// Scenarios
	// ****
	// return costs
	task automatic t_rtn();
		logic [7:0] op [4] = '{OP_RTN_NEAR, OP_RTN_NEAR_IMM, OP_RTN_FAR, OP_RTN_FAR_IMM};
		logic [15:0] cy [8] = '{16'd16, 16'd18, 16'd22, 16'd25, 16'd20, 16'd22, 16'd30, 16'd33};
		for (int i = 0; i < 8; i++) begin
			bus_8bit_i = i[2];
			run(op[i % 4], 8'h34, 8'h12, 8'h00);
			chk("rtn_cyc", decode_o.cycles, cy[i]);
			chk("rtn_kind", 16'(decode_o.kind), 16'(op[i % 4][3] ? K_RTN_FAR : K_RTN_NEAR));
			if (!op[i % 4][0])
				chk("rtn_imm", decode_o.imm16, 16'h1234);
		end
		bus_8bit_i = 1'b0;
	endtask : t_rtn
	task automatic t_jcc();
		logic [4:0] fl [3] = '{5'h15, 5'h0a, 5'h00};
		logic t;
		for (int i = 0; i < 48; i++) begin
			{st.ovf, st.sign, st.zero, st.parity, st.carry} = fl[i / 16];
			t = cond(i[3:0], st);
			run({OP_JCC_HI, i[3:0]}, 8'hf0, 8'h00, 8'h00);
			chk("jcc_taken", 16'(decode_o.taken), 16'(t));
			chk("jcc_cyc", decode_o.cycles, t ? 16'd13 : 16'd4);
			chk("jcc_dest", decode_o.target, st.ip_next - 16'h10);
		end
	endtask : t_jcc
	task automatic t_count();
		logic [7:0] op [8] = '{OP_JCZR, OP_JCZR, OP_LOOP, OP_LOOP, OP_LOOPZ, OP_LOOPZ,
			OP_LOOPNZ, OP_LOOPNZ};
		logic [7:0] tk = 8'b01011001;
		logic [7:0] z = 8'b10010000;
		for (int i = 0; i < 8; i++) begin
			st.count_word = (i == 0) ? 16'h0 : (i < 3 ? 16'h1 : 16'h2);
			st.zero = z[i];
			run(op[i], 8'h08, 8'h00, 8'h00);
			chk("cnt_taken", 16'(decode_o.taken), 16'(tk[i]));
			chk("cnt_cyc", decode_o.cycles, i < 2 ? (tk[i] ? 16'd15 : 16'd5)
				: (tk[i] ? 16'd16 : 16'd6));
			chk("cnt_next", decode_o.count_next, st.count_word - 16'(i > 1));
		end
		st.zero = 1'b0;
	endtask : t_count
	task automatic t_enter();
		logic [15:0] cy [8] = '{16'd15, 16'd25, 16'd38, 16'd54, 16'd19, 16'd29, 16'd46, 16'd66};
		for (int i = 0; i < 8; i++) begin
			bus_8bit_i = i[2];
			run(OP_ENTER, 8'h08, 8'h02, 8'(i % 4));
			chk("ent_cyc", decode_o.cycles, cy[i]);
			chk("ent_size", decode_o.imm16, 16'h0208);
		end
		bus_8bit_i = 1'b0;
	endtask : t_enter
	task automatic t_trap();
		st.ovf = 1'b1;
		run(OP_OVF_TRAP, 8'h00, 8'h00, 8'h00);
		chk("overflow_trap_t", decode_o.cycles, 16'd48);
		st.ovf = 1'b0;
		run(OP_OVF_TRAP, 8'h00, 8'h00, 8'h00);
		chk("overflow_trap_nt", decode_o.cycles, 16'd4);
		run(OP_SW_TRAP, 8'h21, 8'h00, 8'h00);
		chk("int_cyc", decode_o.cycles, 16'd47);
		chk("int_type", 16'(decode_o.aux8), 16'h0021);
		bus_8bit_i = 1'b1;
		run(OP_IEXT, 8'h00, 8'h00, 8'h00);
		chk("iext_cyc", decode_o.cycles, 16'd28);
		bus_8bit_i = 1'b0;
		run(OP_BOUND, 8'h87, 8'h00, 8'h00);
		chk("bnd_min", decode_o.cycles, 16'd33);
		chk("bnd_max", decode_o.cycles_max, 16'd35);
	endtask : t_trap
	task automatic t_flag();
		logic [7:0] op [7] = '{OP_CLR_CARRY, OP_SET_CARRY, OP_INV_CARRY, OP_MASK_INT,
			OP_UNMASK_INT, OP_CLR_DIR, OP_SET_DIR};
		for (int i = 0; i < 7; i++) begin
			run(op[i], 8'h00, 8'h00, 8'h00);
			chk("flag_op", 16'(decode_o.flag_op), 16'(i + 1));
			chk("flag_cyc", decode_o.cycles, 16'd2);
		end
	endtask : t_flag
	task automatic t_ol();
		for (int i = 0; i < 8; i++) begin
			run(OP_BOUND, {5'b10000, 3'(i)}, 8'h34, 8'h12);
			chk("ol_loc", decode_o.ol.operand_location, loc(3'(i)) + 16'h1234);
			chk("ol_seg", 16'(decode_o.ol.segment), 16'(i inside {2, 3, 6} ? SEG_STACK
				: SEG_DATA));
			chk("ol_len", 16'(decode_o.ol.disp_len), 16'h2);
		end
		run(OP_BOUND, 8'h47, 8'hfe, 8'h55);
		chk("ol_d8", decode_o.ol.operand_location, st.base_word - 16'h2);
		run(OP_BOUND, 8'h06, 8'h34, 8'h12);
		chk("ol_dir", decode_o.ol.operand_location, 16'h1234);
		chk("ol_dseg", 16'(decode_o.ol.segment), 16'(SEG_DATA));
		run(OP_BOUND, 8'h00, 8'h34, 8'h12);
		chk("ol_d0", decode_o.ol.operand_location, loc(3'd0));
		run(OP_BOUND, 8'hc1, 8'h00, 8'h00);
		chk("ol_reg", 16'(decode_o.ol.is_reg), 16'h1);
		chk("ol_rval", decode_o.ol.reg_value, {8'h00, st.count_word[7:0]});
	endtask : t_ol
	task automatic t_pfx();
		m_u.send({24'h0, OP_LOCK}, st);
		m_u.send({24'h0, OP_RTN_NEAR}, st);
		chk("lock_kind", 16'(decode_o.kind), 16'(K_PREFIX));
		chk("lock_cyc", decode_o.cycles, 16'd2);
		m_u.idle();
		chk("lock_on", 16'(decode_o.bus_lock), 16'h1);
		run(OP_RTN_NEAR, 8'h00, 8'h00, 8'h00);
		chk("lock_off", 16'(decode_o.bus_lock), 16'h0);
		for (int c = 0; c < 4; c++) begin
			run({3'b001, 2'(c), 3'b110}, 8'h00, 8'h00, 8'h00);
			run(OP_BOUND, 8'h87, 8'h00, 8'h00);
			chk("ovr_seg", 16'(decode_o.ol.segment), 16'(c));
		end
		run(8'h2e, 8'h00, 8'h00, 8'h00);
		run(8'ha4, 8'h00, 8'h00, 8'h00);
		chk("str_seg", 16'(decode_o.ol.segment), 16'(SEG_EXTRA));
		chk("str_loc", decode_o.ol.operand_location, st.destination_index);
	endtask : t_pfx
	// ****
	// Sequence
	// ****
	initial begin
		failures = 0;
		n_tests = 0;
		rst_i = 1'b1;
		bus_8bit_i = 1'b0;
		st = '0;
		st.accumulator_word = 16'h1000;
		st.count_word = 16'h0002;
		st.data_word = 16'h3000;
		st.base_word = 16'h4000;
		st.stack_pointer = 16'h5000;
		st.frame_base_pointer = 16'h6000;
		st.source_index = 16'h0070;
		st.destination_index = 16'h0008;
		st.ip_next = 16'h0100;
		repeat (16) @(negedge ref_clk_i);
		rst_i = 1'b0;
		chk("rst_valid", 16'(decode_valid_o), 16'h0);
		t_rtn();
		t_jcc();
		t_count();
		t_enter();
		t_trap();
		t_flag();
		t_ol();
		t_pfx();
		report_and_stop();
	end
	// Roughly twenty times the cycles the scenarios need
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		failures++;
		report_and_stop();
	end
endmodule : cpu_branch_and_address_decoder_tb_top

// >>> bench/prefetch_model.sv
// Prefetch queue and execution-state model feeding the decoder
`timescale 1ns/1ps
module prefetch_model import decode_pkg::*; (
	input wire logic ref_clk_i,
	output logic fetch_valid_o,
	output fetch_t fetch_o,
	output cpu_state_t state_o
);
	// ****
	// Presentation
	// ****
	initial begin
		fetch_valid_o = 1'b0;
		fetch_o = '0;
		state_o = '0;
	end
	// One instruction per falling edge; back to back by repeated calls
	task automatic send(input fetch_t f, input cpu_state_t s);
		@(negedge ref_clk_i);
		fetch_valid_o = 1'b1;
		fetch_o = f;
		state_o = s;
	endtask : send
	// Invert stale bytes so a decoder that samples off-valid is caught
	task automatic idle();
		@(negedge ref_clk_i);
		fetch_valid_o = 1'b0;
		fetch_o = ~fetch_o;
		state_o = ~state_o;
	endtask : idle
endmodule : prefetch_model

// >>> rtl/branch_decoder.sv
// Control-transfer and processor-control decoder with operand location
`timescale 1ns/1ps

// Summary of operation
// RULE1: near return opcodes, 16 and 18 cycles; code gives 20 and 22 on the 8-bit bus
// RULE2: far return opcodes, 22/25 or 30/33
// RULE3: conditional jump costs 4 or 13
// RULE4: condition pairs from low opcode bits
// RULE5: count-zero jump, 5 or 15 cycles
// RULE6: loop family, 6 or 16 cycles
// RULE7: procedure entry cost by nesting level
// RULE8: overflow trap 48/4, typed trap 47
// RULE9: interrupt exit takes 28 cycles
// RULE10: range check with addressing byte, 33-35
// RULE11: carry flag operations take 2 cycles
// RULE12: interrupt and direction flags, 2 cycles
// RULE13: lock prefix locks following instruction
// RULE14: form selects register or displacement size
// RULE15: base/index sums for selectors 000-010
// RULE16: form 00 selector 110 is direct
// RULE17: location computation costs 4 cycles
// RULE18: displacement precedes immediate data bytes
// RULE19: segment override prefix and codes
// RULE20: register code decode by size flag
// RULE21: frame base operands use stack segment
// RULE22: string destinations always extra segment
// RULE23: remaining selectors' location sums
module branch_decoder
	import decode_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic fetch_valid_i,
	input wire fetch_t fetch_i,
	input wire cpu_state_t state_i,
	input wire logic bus_8bit_i,
	output logic decode_valid_o,
	output decode_t decode_o
);

	// ****************************************
	// Declarations
	// ****************************************
	decode_t dec_d;
	decode_t dec_q;
	logic valid_d;
	logic valid_q;
	logic lock_pend_d;
	logic lock_pend_q;
	logic seg_pend_d;
	logic seg_pend_q;
	logic [1:0] seg_code_d;
	logic [1:0] seg_code_q;
	ol_t ol;
	logic [7:0] op;
	logic cond;
	logic [15:0] rel;
	logic [15:0] cw_dec;
	logic [15:0] lvl_extra;
	logic is_seg_pfx;
	logic is_string;
	logic is_string_dest;

	assign op = fetch_i.b0;
	assign rel = {{8{fetch_i.b1[7]}}, fetch_i.b1};
	assign cw_dec = state_i.count_word - 16'h0001;
	assign is_seg_pfx = (op[7:5] == SEG_PFX_HI) && (op[2:0] == SEG_PFX_LO);
	assign is_string = (op[7:2] == 6'b101001) || (op[7:1] == 7'b1010101)
		|| (op[7:2] == 6'b101011) || (op[7:1] == 7'b0110110);
	// Stores, moves, scans, compares and inputs write or read through the
	// destination index; loads and outputs do not.
	assign is_string_dest = is_string && (op[7:1] != 7'b1010110)
		&& (op[7:1] != 7'b0110111);

	// ****************************************
	// Operand location
	// ****************************************
	// RULE18: displacement follows second byte
	operand_locator u_loc (
		.modrm_i(fetch_i.b1),
		.disp_lo_i(fetch_i.b2),
		.disp_hi_i(fetch_i.b3),
		.word_i(op[0]),
		.seg_ovr_i(seg_pend_q),
		.seg_code_i(seg_code_q),
		.st_i(state_i),
		.ol_o(ol)
	);

	// ****************************************
	// Condition evaluation
	// ****************************************
	always_comb begin
		// RULE4: condition pairs
		unique case (op[3:1])
			3'b000: cond = state_i.ovf;
			3'b001: cond = state_i.carry;
			3'b010: cond = state_i.zero;
			3'b011: cond = state_i.carry | state_i.zero;
			3'b100: cond = state_i.sign;
			3'b101: cond = state_i.parity;
			3'b110: cond = state_i.sign ^ state_i.ovf;
			default: cond = (state_i.sign ^ state_i.ovf) | state_i.zero;
		endcase
		cond = cond ^ op[0];
	end

	// Level cost grows by one step per level above one; level is 8 bits so
	// the product stays well inside 16 bits.
	always_comb begin
		if (bus_8bit_i) begin
			lvl_extra = CYC_ENTER_BASE_8
				+ 16'(CYC_ENTER_STEP_8 * 16'(fetch_i.b3 - 8'd1));
		end else begin
			lvl_extra = CYC_ENTER_BASE
				+ 16'(CYC_ENTER_STEP * 16'(fetch_i.b3 - 8'd1));
		end
	end

	// ****************************************
	// Instruction decode
	// ****************************************
	always_comb begin
		dec_d = dec_q;
		valid_d = 1'b0;
		lock_pend_d = lock_pend_q;
		seg_pend_d = seg_pend_q;
		seg_code_d = seg_code_q;
		if (fetch_valid_i) begin
			valid_d = 1'b1;
			dec_d = '0;
			dec_d.ol = ol;
			dec_d.kind = K_UNKNOWN;
			dec_d.length = 3'd1;
			dec_d.count_next = state_i.count_word;
			dec_d.bus_lock = lock_pend_q;
			lock_pend_d = 1'b0;
			seg_pend_d = 1'b0;
			// RULE22: destination never overridden
			if (is_string_dest) begin
				dec_d.ol.operand_location = state_i.destination_index;
				dec_d.ol.segment = SEG_EXTRA;
				dec_d.ol.disp_len = 2'd0;
			end
			if (op == OP_LOCK) begin
				// RULE13: lock the next instruction
				dec_d.kind = K_PREFIX;
				dec_d.cycles = CYC_PREFIX;
				lock_pend_d = 1'b1;
				seg_pend_d = seg_pend_q;
			end else if (is_seg_pfx) begin
				// RULE19: override prefix held pending
				dec_d.kind = K_PREFIX;
				dec_d.cycles = CYC_PREFIX;
				seg_pend_d = 1'b1;
				seg_code_d = op[4:3];
				lock_pend_d = lock_pend_q;
			end else if (op[7:4] == OP_JCC_HI) begin
				// RULE3: jump cost by outcome
				dec_d.kind = K_JCC;
				dec_d.length = 3'd2;
				dec_d.taken = cond;
				dec_d.cycles = cond ? CYC_JCC_T : CYC_JCC_NT;
				dec_d.target = state_i.ip_next + rel;
			end else begin
				unique case (op)
					// RULE1: near return
					OP_RTN_NEAR, OP_RTN_NEAR_IMM: begin
						dec_d.kind = K_RTN_NEAR;
						dec_d.taken = 1'b1;
						dec_d.length = op[0] ? 3'd1 : 3'd3;
						dec_d.imm16 = op[0] ? 16'h0000 : {fetch_i.b2, fetch_i.b1};
						if (bus_8bit_i) begin
							dec_d.cycles = op[0] ? CYC_RTN_NEAR_8 : CYC_RTN_NEAR_IMM_8;
						end else begin
							dec_d.cycles = op[0] ? CYC_RTN_NEAR : CYC_RTN_NEAR_IMM;
						end
					end
					// RULE2: far return
					OP_RTN_FAR, OP_RTN_FAR_IMM: begin
						dec_d.kind = K_RTN_FAR;
						dec_d.taken = 1'b1;
						dec_d.length = op[0] ? 3'd1 : 3'd3;
						dec_d.imm16 = op[0] ? 16'h0000 : {fetch_i.b2, fetch_i.b1};
						if (bus_8bit_i) begin
							dec_d.cycles = op[0] ? CYC_RTN_FAR_8 : CYC_RTN_FAR_IMM_8;
						end else begin
							dec_d.cycles = op[0] ? CYC_RTN_FAR : CYC_RTN_FAR_IMM;
						end
					end
					// RULE5: branch only on zero count
					OP_JCZR: begin
						dec_d.kind = K_JCZR;
						dec_d.length = 3'd2;
						dec_d.taken = (state_i.count_word == 16'h0000);
						dec_d.cycles = dec_d.taken ? CYC_JCZR_T : CYC_JCZR_NT;
						dec_d.target = state_i.ip_next + rel;
					end
					// RULE6: loop family
					OP_LOOP, OP_LOOPZ, OP_LOOPNZ: begin
						dec_d.kind = K_LOOP;
						dec_d.length = 3'd2;
						dec_d.count_next = cw_dec;
						if (op == OP_LOOP) begin
							dec_d.taken = (cw_dec != 16'h0000);
						end else if (op == OP_LOOPZ) begin
							dec_d.taken = (cw_dec != 16'h0000) && state_i.zero;
						end else begin
							dec_d.taken = (cw_dec != 16'h0000) && !state_i.zero;
						end
						dec_d.cycles = dec_d.taken ? CYC_LOOP_T : CYC_LOOP_NT;
						dec_d.target = state_i.ip_next + rel;
					end
					// RULE7: entry cost by level
					OP_ENTER: begin
						dec_d.kind = K_ENTER;
						dec_d.length = 3'd4;
						dec_d.imm16 = {fetch_i.b2, fetch_i.b1};
						dec_d.aux8 = fetch_i.b3;
						if (fetch_i.b3 == 8'd0) begin
							dec_d.cycles = bus_8bit_i ? CYC_ENTER_L0_8 : CYC_ENTER_L0;
						end else if (fetch_i.b3 == 8'd1) begin
							dec_d.cycles = bus_8bit_i ? CYC_ENTER_L1_8 : CYC_ENTER_L1;
						end else begin
							dec_d.cycles = lvl_extra;
						end
					end
					// RULE8: overflow trap
					OP_OVF_TRAP: begin
						dec_d.kind = K_TRAP;
						dec_d.taken = state_i.ovf;
						dec_d.aux8 = OVF_TRAP_TYPE;
						dec_d.cycles = state_i.ovf ? CYC_OVF_T : CYC_OVF_NT;
					end
					// RULE8: typed trap
					OP_SW_TRAP: begin
						dec_d.kind = K_TRAP;
						dec_d.taken = 1'b1;
						dec_d.length = 3'd2;
						dec_d.aux8 = fetch_i.b1;
						dec_d.cycles = CYC_SW_TRAP;
					end
					// RULE9: interrupt exit
					OP_IEXT: begin
						dec_d.kind = K_IEXT;
						dec_d.taken = 1'b1;
						dec_d.cycles = CYC_IEXT;
					end
					// RULE10: range check
					OP_BOUND: begin
						dec_d.kind = K_BOUND;
						dec_d.length = 3'(3'd2 + 3'(ol.disp_len));
						// RULE17: location time already included
						dec_d.cycles = CYC_BOUND_MIN;
						dec_d.cycles_max = CYC_BOUND_MAX;
						dec_d.aux8 = {5'h00, fetch_i.b1[5:3]};
					end
					// RULE11: carry operations
					OP_CLR_CARRY, OP_SET_CARRY, OP_INV_CARRY: begin
						dec_d.kind = K_FLAG;
						dec_d.cycles = CYC_FLAG;
						dec_d.flag_op = (op == OP_CLR_CARRY) ? F_CLR_CARRY
							: (op == OP_SET_CARRY) ? F_SET_CARRY : F_INV_CARRY;
					end
					// RULE12: interrupt and direction
					OP_MASK_INT, OP_UNMASK_INT, OP_CLR_DIR, OP_SET_DIR: begin
						dec_d.kind = K_FLAG;
						dec_d.cycles = CYC_FLAG;
						dec_d.flag_op = (op == OP_MASK_INT) ? F_MASK_INT
							: (op == OP_UNMASK_INT) ? F_UNMASK_INT
							: (op == OP_CLR_DIR) ? F_CLR_DIR : F_SET_DIR;
					end
					default: begin
						dec_d.kind = K_UNKNOWN;
					end
				endcase
			end
			if (dec_d.cycles_max == 16'h0000) begin
				dec_d.cycles_max = dec_d.cycles;
			end
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			dec_q <= '0;
			valid_q <= 1'b0;
			lock_pend_q <= 1'b0;
			seg_pend_q <= 1'b0;
			seg_code_q <= SEG_EXTRA;
		end else begin
			dec_q <= dec_d;
			valid_q <= valid_d;
			lock_pend_q <= lock_pend_d;
			seg_pend_q <= seg_pend_d;
			seg_code_q <= seg_code_d;
		end
	end

	assign decode_valid_o = valid_q;
	assign decode_o = dec_q;

endmodule : branch_decoder

// >>> rtl/decode_pkg.sv
// Shared types and constants for the branch and operand-location decoder
package decode_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_RTN_NEAR = 8'hc3;
	localparam logic [7:0] OP_RTN_NEAR_IMM = 8'hc2;
	localparam logic [7:0] OP_RTN_FAR = 8'hcb;
	localparam logic [7:0] OP_RTN_FAR_IMM = 8'hca;
	localparam logic [3:0] OP_JCC_HI = 4'h7;
	localparam logic [7:0] OP_JCZR = 8'he3;
	localparam logic [7:0] OP_LOOP = 8'he2;
	localparam logic [7:0] OP_LOOPZ = 8'he1;
	localparam logic [7:0] OP_LOOPNZ = 8'he0;
	localparam logic [7:0] OP_ENTER = 8'hc8;
	localparam logic [7:0] OP_OVF_TRAP = 8'hce;
	localparam logic [7:0] OP_SW_TRAP = 8'hcd;
	localparam logic [7:0] OP_IEXT = 8'hcf;
	localparam logic [7:0] OP_BOUND = 8'h62;
	localparam logic [7:0] OP_CLR_CARRY = 8'hf8;
	localparam logic [7:0] OP_SET_CARRY = 8'hf9;
	localparam logic [7:0] OP_INV_CARRY = 8'hf5;
	localparam logic [7:0] OP_MASK_INT = 8'hfa;
	localparam logic [7:0] OP_UNMASK_INT = 8'hfb;
	localparam logic [7:0] OP_CLR_DIR = 8'hfc;
	localparam logic [7:0] OP_SET_DIR = 8'hfd;
	localparam logic [7:0] OP_LOCK = 8'hf0;
	localparam logic [2:0] SEG_PFX_HI = 3'b001;
	localparam logic [2:0] SEG_PFX_LO = 3'b110;
	// Overflow trap vector, arbitrary neutral value
	localparam logic [7:0] OVF_TRAP_TYPE = 8'h04;

	// ****************************************
	// Addressing fields
	// ****************************************
	localparam logic [1:0] FORM_NO_DISP = 2'b00;
	localparam logic [1:0] FORM_DISP8 = 2'b01;
	localparam logic [1:0] FORM_DISP16 = 2'b10;
	localparam logic [1:0] FORM_REG = 2'b11;
	localparam logic [2:0] SEL_DIRECT = 3'b110;
	localparam logic [1:0] SEG_EXTRA = 2'b00;
	localparam logic [1:0] SEG_CODE = 2'b01;
	localparam logic [1:0] SEG_STACK = 2'b10;
	localparam logic [1:0] SEG_DATA = 2'b11;

	// ****************************************
	// Cycle costs (16-bit bus part, then 8-bit part)
	// ****************************************
	localparam logic [15:0] CYC_RTN_NEAR = 16'd16;
	localparam logic [15:0] CYC_RTN_NEAR_IMM = 16'd18;
	localparam logic [15:0] CYC_RTN_NEAR_8 = 16'd20;
	localparam logic [15:0] CYC_RTN_NEAR_IMM_8 = 16'd22;
	localparam logic [15:0] CYC_RTN_FAR = 16'd22;
	localparam logic [15:0] CYC_RTN_FAR_IMM = 16'd25;
	localparam logic [15:0] CYC_RTN_FAR_8 = 16'd30;
	localparam logic [15:0] CYC_RTN_FAR_IMM_8 = 16'd33;
	localparam logic [15:0] CYC_JCC_NT = 16'd4;
	localparam logic [15:0] CYC_JCC_T = 16'd13;
	localparam logic [15:0] CYC_JCZR_NT = 16'd5;
	localparam logic [15:0] CYC_JCZR_T = 16'd15;
	localparam logic [15:0] CYC_LOOP_NT = 16'd6;
	localparam logic [15:0] CYC_LOOP_T = 16'd16;
	localparam logic [15:0] CYC_ENTER_L0 = 16'd15;
	localparam logic [15:0] CYC_ENTER_L1 = 16'd25;
	localparam logic [15:0] CYC_ENTER_BASE = 16'd22;
	localparam logic [15:0] CYC_ENTER_STEP = 16'd16;
	localparam logic [15:0] CYC_ENTER_L0_8 = 16'd19;
	localparam logic [15:0] CYC_ENTER_L1_8 = 16'd29;
	localparam logic [15:0] CYC_ENTER_BASE_8 = 16'd26;
	localparam logic [15:0] CYC_ENTER_STEP_8 = 16'd20;
	localparam logic [15:0] CYC_OVF_T = 16'd48;
	localparam logic [15:0] CYC_OVF_NT = 16'd4;
	localparam logic [15:0] CYC_SW_TRAP = 16'd47;
	localparam logic [15:0] CYC_IEXT = 16'd28;
	localparam logic [15:0] CYC_BOUND_MIN = 16'd33;
	localparam logic [15:0] CYC_BOUND_MAX = 16'd35;
	localparam logic [15:0] CYC_FLAG = 16'd2;
	localparam logic [15:0] CYC_PREFIX = 16'd2;
	localparam logic [15:0] CYC_OL = 16'd4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		K_NONE = 4'b0000, K_PREFIX = 4'b0001, K_RTN_NEAR = 4'b0010,
		K_RTN_FAR = 4'b0011, K_JCC = 4'b0100, K_JCZR = 4'b0101,
		K_LOOP = 4'b0110, K_ENTER = 4'b0111, K_TRAP = 4'b1000,
		K_IEXT = 4'b1001, K_BOUND = 4'b1010, K_FLAG = 4'b1011,
		K_UNKNOWN = 4'b1100
	} kind_t;

	typedef enum logic [2:0] {
		F_NONE = 3'b000, F_CLR_CARRY = 3'b001, F_SET_CARRY = 3'b010,
		F_INV_CARRY = 3'b011, F_MASK_INT = 3'b100, F_UNMASK_INT = 3'b101,
		F_CLR_DIR = 3'b110, F_SET_DIR = 3'b111
	} flag_op_t;

	typedef struct packed {
		logic [7:0] b3;
		logic [7:0] b2;
		logic [7:0] b1;
		logic [7:0] b0;
	} fetch_t;

	typedef struct packed {
		logic [15:0] accumulator_word;
		logic [15:0] count_word;
		logic [15:0] data_word;
		logic [15:0] base_word;
		logic [15:0] stack_pointer;
		logic [15:0] frame_base_pointer;
		logic [15:0] source_index;
		logic [15:0] destination_index;
		logic [15:0] ip_next;
		logic ovf;
		logic sign;
		logic zero;
		logic parity;
		logic carry;
	} cpu_state_t;

	typedef struct packed {
		logic [15:0] operand_location;
		logic [1:0] segment;
		logic [1:0] disp_len;
		logic is_reg;
		logic [15:0] reg_value;
	} ol_t;

	typedef struct packed {
		kind_t kind;
		logic taken;
		logic [2:0] length;
		logic [15:0] cycles;
		logic [15:0] cycles_max;
		logic [15:0] target;
		logic [15:0] imm16;
		logic [7:0] aux8;
		logic [15:0] count_next;
		flag_op_t flag_op;
		ol_t ol;
		logic bus_lock;
	} decode_t;

endpackage : decode_pkg

// >>> rtl/operand_locator.sv
// Operand location, segment and register operand decode from the addressing byte
`timescale 1ns/1ps

module operand_locator
	import decode_pkg::*;
(
	input wire logic [7:0] modrm_i,
	input wire logic [7:0] disp_lo_i,
	input wire logic [7:0] disp_hi_i,
	input wire logic word_i,
	input wire logic seg_ovr_i,
	input wire logic [1:0] seg_code_i,
	input wire cpu_state_t st_i,
	output ol_t ol_o
);
	logic [1:0] form;
	logic [2:0] sel;
	logic [15:0] disp;
	logic [15:0] base;
	logic fb_based;
	logic [15:0] regs [8];

	assign form = modrm_i[7:6];
	assign sel = modrm_i[2:0];
	assign regs[0] = st_i.accumulator_word;
	assign regs[1] = st_i.count_word;
	assign regs[2] = st_i.data_word;
	assign regs[3] = st_i.base_word;
	assign regs[4] = st_i.stack_pointer;
	assign regs[5] = st_i.frame_base_pointer;
	assign regs[6] = st_i.source_index;
	assign regs[7] = st_i.destination_index;

	always_comb begin
		// RULE14: form picks displacement
		unique case (form)
			FORM_DISP8: disp = {{8{disp_lo_i[7]}}, disp_lo_i};
			FORM_DISP16: disp = {disp_hi_i, disp_lo_i};
			default: disp = 16'h0000;
		endcase
		fb_based = 1'b0;
		// RULE15: first three memory selectors
		// RULE23: remaining memory selectors
		unique case (sel)
			3'b000: base = st_i.base_word + st_i.source_index;
			3'b001: base = st_i.base_word + st_i.destination_index;
			3'b010: base = st_i.frame_base_pointer + st_i.source_index;
			3'b011: base = st_i.frame_base_pointer + st_i.destination_index;
			3'b100: base = st_i.source_index;
			3'b101: base = st_i.destination_index;
			3'b110: base = st_i.frame_base_pointer;
			default: base = st_i.base_word;
		endcase
		if (sel == 3'b010 || sel == 3'b011 || sel == SEL_DIRECT) begin
			fb_based = 1'b1;
		end
		ol_o.disp_len = 2'd0;
		if (form == FORM_DISP8) begin
			ol_o.disp_len = 2'd1;
		end else if (form == FORM_DISP16) begin
			ol_o.disp_len = 2'd2;
		end
		ol_o.operand_location = base + disp;
		// RULE16: direct address form
		if (form == FORM_NO_DISP && sel == SEL_DIRECT) begin
			ol_o.operand_location = {disp_hi_i, disp_lo_i};
			ol_o.disp_len = 2'd2;
			fb_based = 1'b0;
		end
		// RULE21: frame base uses stack segment
		ol_o.segment = fb_based ? SEG_STACK : SEG_DATA;
		if (seg_ovr_i) begin
			ol_o.segment = seg_code_i;
		end
		ol_o.is_reg = (form == FORM_REG);
		// RULE14: register form uses selector
		// RULE20: word or byte register decode
		if (word_i) begin
			ol_o.reg_value = regs[sel];
		end else if (sel[2]) begin
			ol_o.reg_value = {8'h00, regs[{1'b0, sel[1:0]}][15:8]};
		end else begin
			ol_o.reg_value = {8'h00, regs[{1'b0, sel[1:0]}][7:0]};
		end
	end

endmodule : operand_locator
